/* rtl/tmc_pkg.sv */
// Purpose: shared constants and types for the 16-bit timer mode and output control block
// Assumes: Avalon-MM byte addresses, one 32-bit word per register
// Notes:   8-bit registers sit in the low byte, upper bits read zero
package tmc_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [4:0] OFS_CTRL_A  = 5'h00;
  localparam logic [4:0] OFS_CTRL_B  = 5'h04;
  localparam logic [4:0] OFS_CMP_A   = 5'h08;
  localparam logic [4:0] OFS_CMP_B   = 5'h0C;
  localparam logic [4:0] OFS_CAPTURE = 5'h10;
  localparam logic [4:0] OFS_COUNT   = 5'h14;
  localparam logic [4:0] OFS_STATUS  = 5'h18;
  localparam logic [4:0] OFS_PORT    = 5'h1C;

  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [7:0] CTRL_A_WMASK = 8'hF3;
  localparam logic [7:0] CTRL_B_WMASK = 8'hDF;

  // control A fields
  localparam int CA_OM_A_LSB = 6;
  localparam int CA_OM_B_LSB = 4;
  localparam int CA_WM_LSB   = 0;
  // control B fields
  localparam int CB_FILTER   = 7;
  localparam int CB_EDGE     = 6;
  localparam int CB_WM_LSB   = 3;
  localparam int CB_CS_LSB   = 0;
  // status fields, write one to clear
  localparam int ST_OVF      = 0;
  localparam int ST_MATCH_A  = 1;
  localparam int ST_MATCH_B  = 2;
  localparam int ST_CAPT     = 5;
  // port fields
  localparam int PT_DIR_A    = 0;
  localparam int PT_DIR_B    = 1;
  localparam int PT_DATA_A   = 2;
  localparam int PT_DATA_B   = 3;

  // ****************************************************************
  // counter limits and selections
  // ****************************************************************
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] CNT_MAX    = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT   = 16'h00FF;
  localparam logic [15:0] TOP_9BIT   = 16'h01FF;
  localparam logic [15:0] TOP_10BIT  = 16'h03FF;

  localparam logic [2:0] CS_STOP    = 3'h0;
  localparam logic [2:0] CS_DIV1    = 3'h1;
  localparam logic [2:0] CS_DIV8    = 3'h2;
  localparam logic [2:0] CS_DIV64   = 3'h3;
  localparam logic [2:0] CS_DIV256  = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXTFALL = 3'h6;
  localparam logic [2:0] CS_EXTRISE = 3'h7;

  localparam logic [9:0] PRE_MASK8    = 10'h007;
  localparam logic [9:0] PRE_MASK64   = 10'h03F;
  localparam logic [9:0] PRE_MASK256  = 10'h0FF;
  localparam logic [9:0] PRE_MASK1024 = 10'h3FF;

  localparam logic [2:0] FILTER_SAMPLES = 3'h4;

  localparam logic [1:0] OM_OFF    = 2'h0;
  localparam logic [1:0] OM_TOGGLE = 2'h1;
  localparam logic [1:0] OM_CLEAR  = 2'h2;
  localparam logic [1:0] OM_SET    = 2'h3;

  localparam logic [3:0] WM_NORMAL   = 4'h0;
  localparam logic [3:0] WM_PC8      = 4'h1;
  localparam logic [3:0] WM_PC9      = 4'h2;
  localparam logic [3:0] WM_PC10     = 4'h3;
  localparam logic [3:0] WM_CTC_CMPA = 4'h4;
  localparam logic [3:0] WM_FAST8    = 4'h5;
  localparam logic [3:0] WM_FAST9    = 4'h6;
  localparam logic [3:0] WM_FAST10   = 4'h7;
  localparam logic [3:0] WM_PFC_CAPT = 4'h8;
  localparam logic [3:0] WM_PFC_CMPA = 4'h9;
  localparam logic [3:0] WM_PC_CAPT  = 4'hA;
  localparam logic [3:0] WM_PC_CMPA  = 4'hB;
  localparam logic [3:0] WM_CTC_CAPT = 4'hC;
  localparam logic [3:0] WM_RESERVED = 4'hD;
  localparam logic [3:0] WM_FAST_CAPT = 4'hE;
  localparam logic [3:0] WM_FAST_CMPA = 4'hF;

  typedef enum logic [1:0] {FAM_NONPWM = 2'h0, FAM_FAST = 2'h1, FAM_DUAL = 2'h3} tmc_family_type;
  typedef enum logic {DIR_UP = 1'b0, DIR_DOWN = 1'b1} tmc_dir_type;

endpackage

/* rtl/tmc_timer16.sv */
// Purpose: 16-bit timer with waveform mode and compare output control, Avalon-MM slave
// Assumes: all inputs synchronous to clk_i; one wait state on every bus access
// Notes:   pins use output plus output enable; capture and count pins are plain inputs
//
// Function
// [RULE_01] nonzero channel A output mode puts its waveform on the pin
// [RULE_02] nonzero channel B output mode puts its waveform on the pin
// [RULE_03] pin driver enabled only when the pin direction bit selects output
// [RULE_04] output mode 00 disconnects the waveform in every mode
// [RULE_05] non-PWM: 01 toggles, 10 clears, 11 sets on compare match
// [RULE_06] fast PWM: 10 clears on match sets at TOP, 11 opposite
// [RULE_07] fast PWM 01 toggles A only in modes 14, 15; else disconnected
// [RULE_08] fast PWM compare equal to TOP: match ignored, only TOP action
// [RULE_09] dual-slope: 10 clears on up match, sets on down; 11 opposite
// [RULE_10] dual-slope 01 toggles A only in modes 8 to 11; else disconnected
// [RULE_11] control A bits 3 and 2 read as zero
// [RULE_12] waveform mode is control B bits 4:3 over control A bits 1:0
// [RULE_13] normal and clear-on-match: TOP, immediate update, overflow at MAX
// [RULE_14] phase correct modes: TOP, update at TOP, overflow at BOTTOM
// [RULE_15] phase and frequency correct: update and overflow at BOTTOM
// [RULE_16] fast PWM: fixed or register TOP, update and overflow at TOP
// [RULE_17] clock select: stop, prescaled I/O clock, or external pin edges
// [RULE_18] capture edge select: zero falling edge, one rising edge
// [RULE_19] noise filter needs four equal samples before capture input changes
// [RULE_20] control writes act next edge; reset clears all control bits
`timescale 1ns/1ps
`default_nettype none

module tmc_timer16
  import tmc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        external_count_pin_i,
  input  wire logic        capture_input_pin_i,
  output logic             chan_a_wave_pin_o,
  output logic             chan_a_wave_pin_oe_o,
  output logic             chan_b_wave_pin_o,
  output logic             chan_b_wave_pin_oe_o
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic tmc_family_type family_of(input logic [3:0] m);
    case (m)
      WM_PC8, WM_PC9, WM_PC10, WM_PFC_CAPT, WM_PFC_CMPA, WM_PC_CAPT, WM_PC_CMPA:
        family_of = FAM_DUAL;
      WM_FAST8, WM_FAST9, WM_FAST10, WM_FAST_CAPT, WM_FAST_CMPA:
        family_of = FAM_FAST;
      default:
        family_of = FAM_NONPWM;
    endcase
  endfunction

  function automatic logic [15:0] top_of(input logic [3:0]  m,
                                         input logic [15:0] cmpa,
                                         input logic [15:0] capt);
    case (m)
      WM_PC8, WM_FAST8:                                         top_of = TOP_8BIT;
      WM_PC9, WM_FAST9:                                         top_of = TOP_9BIT;
      WM_PC10, WM_FAST10:                                       top_of = TOP_10BIT;
      WM_CTC_CMPA, WM_PFC_CMPA, WM_PC_CMPA, WM_FAST_CMPA:       top_of = cmpa;
      WM_PFC_CAPT, WM_PC_CAPT, WM_CTC_CAPT, WM_FAST_CAPT:       top_of = capt;
      default:                                                  top_of = CNT_MAX;
    endcase
  endfunction

  // toggle_ok: the 01 setting is legal for this channel in the current mode
  function automatic logic is_connected(input logic [1:0] om,
                                        input tmc_family_type fam,
                                        input logic toggle_ok);
    is_connected = (om != OM_OFF) &&                              // RULE_04
                   !(om == OM_TOGGLE && fam != FAM_NONPWM && !toggle_ok); // RULE_07 RULE_10
  endfunction

  function automatic logic wave_next(input logic           cur,
                                     input logic [1:0]     om,
                                     input tmc_family_type fam,
                                     input logic           toggle_ok,
                                     input logic           match,
                                     input logic           at_top,
                                     input logic           cmp_is_top,
                                     input tmc_dir_type    dir);
    wave_next = cur;
    case (fam)
      FAM_NONPWM:
        if (match)
        begin
          case (om)
            OM_TOGGLE: wave_next = ~cur;                          // RULE_05
            OM_CLEAR:  wave_next = 1'b0;
            OM_SET:    wave_next = 1'b1;
            default:   wave_next = cur;
          endcase
        end
      FAM_FAST:
        if (om[1])
        begin
          if (at_top)
            wave_next = ~om[0];                                   // RULE_06
          else if (match && !cmp_is_top)                          // RULE_08
            wave_next = om[0];
        end
        else if (om == OM_TOGGLE && toggle_ok && match)
          wave_next = ~cur;                                       // RULE_07
      FAM_DUAL:
        if (om[1] && match)
          wave_next = (dir == DIR_UP) ? om[0] : ~om[0];           // RULE_09
        else if (om == OM_TOGGLE && toggle_ok && match)
          wave_next = ~cur;                                       // RULE_10
      default:
        wave_next = cur;
    endcase
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // ****************************************************************
  // bus slave: one wait state, write at the second edge, read data registered at the first
  // ****************************************************************
  logic        ack_q;
  logic        wr_go;
  logic [31:0] rdata_d;

  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_q;
  assign wr_go = avs_write_i && ack_q;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      ack_q <= 1'b0;
    else
      ack_q <= (avs_read_i || avs_write_i) && !ack_q;
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0]  ctrl_a_q;
  logic [7:0]  ctrl_b_q;
  logic [15:0] cmp_a_buf_q;
  logic [15:0] cmp_b_buf_q;
  logic [15:0] cmp_a_q;
  logic [15:0] cmp_b_q;
  logic [15:0] capture_value_q;
  logic [15:0] count_value_q;
  logic [7:0]  status_q;
  logic [3:0]  port_q;
  tmc_dir_type dir_q;

  logic [3:0]     waveform_mode;
  tmc_family_type fam;
  logic [15:0]    top;
  logic           tick;
  logic           at_top;
  logic           at_bottom;
  logic           upd_now;
  logic           ovf_evt;
  logic           match_a;
  logic           match_b;
  logic           capt_evt;
  logic           capt_is_top;
  logic           tog_ok_a;

  assign waveform_mode = {ctrl_b_q[CB_WM_LSB +: 2], ctrl_a_q[CA_WM_LSB +: 2]}; // RULE_12
  assign fam           = family_of(waveform_mode);
  assign top           = top_of(waveform_mode, cmp_a_q, capture_value_q);
  assign at_top        = (count_value_q == top);
  assign at_bottom     = (count_value_q == CNT_BOTTOM);
  assign capt_is_top   = (waveform_mode == WM_PFC_CAPT) || (waveform_mode == WM_PC_CAPT) ||
                         (waveform_mode == WM_CTC_CAPT) || (waveform_mode == WM_FAST_CAPT);
  assign tog_ok_a      = (waveform_mode == WM_FAST_CAPT) || (waveform_mode == WM_FAST_CMPA) ||
                         (waveform_mode >= WM_PFC_CAPT && waveform_mode <= WM_PC_CMPA);

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      ctrl_a_q <= CTRL_RESET;                                     // RULE_20
      ctrl_b_q <= CTRL_RESET;
    end
    else if (wr_go && avs_byteenable_i[0])
    begin
      if (avs_address_i == OFS_CTRL_A)
        ctrl_a_q <= avs_writedata_i[7:0] & CTRL_A_WMASK;          // RULE_11 RULE_20
      if (avs_address_i == OFS_CTRL_B)
        ctrl_b_q <= avs_writedata_i[7:0] & CTRL_B_WMASK;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      port_q <= 4'h0;
    else if (wr_go && avs_byteenable_i[0] && avs_address_i == OFS_PORT)
      port_q <= avs_writedata_i[3:0];
  end

  // ****************************************************************
  // clock source selection
  // ****************************************************************
  logic [9:0] presc_q;
  logic       ext_prev_q;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      presc_q    <= 10'h000;
      ext_prev_q <= 1'b0;
    end
    else
    begin
      presc_q    <= presc_q + 10'h001;
      ext_prev_q <= external_count_pin_i;
    end
  end

  always_comb
  begin
    case (ctrl_b_q[CB_CS_LSB +: 3])                               // RULE_17
      CS_DIV1:    tick = 1'b1;
      CS_DIV8:    tick = (presc_q & PRE_MASK8) == PRE_MASK8;
      CS_DIV64:   tick = (presc_q & PRE_MASK64) == PRE_MASK64;
      CS_DIV256:  tick = (presc_q & PRE_MASK256) == PRE_MASK256;
      CS_DIV1024: tick = presc_q == PRE_MASK1024;
      CS_EXTFALL: tick = ext_prev_q && !external_count_pin_i;
      CS_EXTRISE: tick = !ext_prev_q && external_count_pin_i;
      default:    tick = 1'b0;
    endcase
  end

  // ****************************************************************
  // counter and compare double buffer
  // ****************************************************************
  assign match_a = tick && (count_value_q == cmp_a_q);
  assign match_b = tick && (count_value_q == cmp_b_q);

  always_comb
  begin
    case (fam)
      FAM_FAST: ovf_evt = tick && at_top;                         // RULE_16
      FAM_DUAL: ovf_evt = tick && at_bottom;                      // RULE_14 RULE_15
      default:  ovf_evt = tick && (count_value_q == CNT_MAX);     // RULE_13
    endcase
    if (waveform_mode == WM_PFC_CAPT || waveform_mode == WM_PFC_CMPA)
      upd_now = tick && at_bottom;                                // RULE_15
    else
      upd_now = tick && at_top;                                   // RULE_14 RULE_16
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      count_value_q <= CNT_BOTTOM;
      dir_q         <= DIR_UP;
    end
    else if (wr_go && avs_address_i == OFS_COUNT)
      count_value_q <= merge16(count_value_q, avs_writedata_i, avs_byteenable_i);
    else if (tick)
    begin
      if (fam != FAM_DUAL)
      begin
        count_value_q <= at_top ? CNT_BOTTOM : count_value_q + 16'h0001;
        dir_q         <= DIR_UP;
      end
      else
      begin
        case (dir_q)
          DIR_UP:
            if (count_value_q >= top)
            begin
              dir_q         <= DIR_DOWN;
              count_value_q <= count_value_q - 16'h0001;
            end
            else
              count_value_q <= count_value_q + 16'h0001;
          DIR_DOWN:
            if (at_bottom)
            begin
              dir_q         <= DIR_UP;
              count_value_q <= count_value_q + 16'h0001;
            end
            else
              count_value_q <= count_value_q - 16'h0001;
          default:
            dir_q <= DIR_UP;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      cmp_a_buf_q <= 16'h0000;
      cmp_b_buf_q <= 16'h0000;
    end
    else if (wr_go)
    begin
      if (avs_address_i == OFS_CMP_A)
        cmp_a_buf_q <= merge16(cmp_a_buf_q, avs_writedata_i, avs_byteenable_i);
      if (avs_address_i == OFS_CMP_B)
        cmp_b_buf_q <= merge16(cmp_b_buf_q, avs_writedata_i, avs_byteenable_i);
    end
  end

  // non-PWM modes follow the buffer at once; PWM modes only on their update point
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      cmp_a_q <= 16'h0000;
      cmp_b_q <= 16'h0000;
    end
    else if (fam == FAM_NONPWM || upd_now)                        // RULE_13
    begin
      cmp_a_q <= cmp_a_buf_q;
      cmp_b_q <= cmp_b_buf_q;
    end
  end

  // ****************************************************************
  // capture input: optional filter, edge select
  // ****************************************************************
  logic       filt_q;
  logic [2:0] same_cnt_q;
  logic       capt_lvl;
  logic       capt_prev_q;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      filt_q     <= 1'b0;
      same_cnt_q <= 3'h0;
    end
    else if (capture_input_pin_i == filt_q)
      same_cnt_q <= 3'h0;
    else if (same_cnt_q == FILTER_SAMPLES - 3'h1)
    begin
      filt_q     <= capture_input_pin_i;                          // RULE_19
      same_cnt_q <= 3'h0;
    end
    else
      same_cnt_q <= same_cnt_q + 3'h1;
  end

  assign capt_lvl = ctrl_b_q[CB_FILTER] ? filt_q : capture_input_pin_i;
  assign capt_evt = !capt_is_top &&
                    (ctrl_b_q[CB_EDGE] ? (capt_lvl && !capt_prev_q)
                                       : (!capt_lvl && capt_prev_q)); // RULE_18

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      capt_prev_q <= 1'b0;
    else
      capt_prev_q <= capt_lvl;
  end

  // capture register is software-writable only while it serves as TOP
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      capture_value_q <= 16'h0000;
    else if (capt_evt)
      capture_value_q <= count_value_q;
    else if (wr_go && capt_is_top && avs_address_i == OFS_CAPTURE)
      capture_value_q <= merge16(capture_value_q, avs_writedata_i, avs_byteenable_i);
  end

  // ****************************************************************
  // status flags: hardware set wins over software clear
  // ****************************************************************
  logic [7:0] st_set;
  logic [7:0] st_clr;

  always_comb
  begin
    st_set              = 8'h00;
    st_set[ST_OVF]      = ovf_evt;
    st_set[ST_MATCH_A]  = match_a;
    st_set[ST_MATCH_B]  = match_b;
    st_set[ST_CAPT]     = capt_evt || (capt_is_top && tick && at_top);
    st_clr = (wr_go && avs_byteenable_i[0] && avs_address_i == OFS_STATUS) ?
             avs_writedata_i[7:0] : 8'h00;
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      status_q <= 8'h00;
    else
      status_q <= (status_q & ~st_clr) | st_set;
  end

  // ****************************************************************
  // waveform outputs and pins
  // ****************************************************************
  logic wave_a_q;
  logic wave_b_q;
  logic conn_a;
  logic conn_b;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      wave_a_q <= 1'b0;
      wave_b_q <= 1'b0;
    end
    else if (tick)
    begin
      wave_a_q <= wave_next(wave_a_q, ctrl_a_q[CA_OM_A_LSB +: 2], fam, tog_ok_a,
                            match_a, at_top, cmp_a_q == top, dir_q);
      wave_b_q <= wave_next(wave_b_q, ctrl_a_q[CA_OM_B_LSB +: 2], fam, 1'b0,
                            match_b, at_top, cmp_b_q == top, dir_q);
    end
  end

  assign conn_a = is_connected(ctrl_a_q[CA_OM_A_LSB +: 2], fam, tog_ok_a);
  assign conn_b = is_connected(ctrl_a_q[CA_OM_B_LSB +: 2], fam, 1'b0);

  assign chan_a_wave_pin_o    = conn_a ? wave_a_q : port_q[PT_DATA_A];  // RULE_01
  assign chan_b_wave_pin_o    = conn_b ? wave_b_q : port_q[PT_DATA_B];  // RULE_02
  assign chan_a_wave_pin_oe_o = port_q[PT_DIR_A];                      // RULE_03
  assign chan_b_wave_pin_oe_o = port_q[PT_DIR_B];                      // RULE_03

  // ****************************************************************
  // read data, latched during the wait cycle
  // ****************************************************************
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    case (avs_address_i)
      OFS_CTRL_A:  rdata_d[7:0]  = ctrl_a_q;                      // RULE_11
      OFS_CTRL_B:  rdata_d[7:0]  = ctrl_b_q;
      OFS_CMP_A:   rdata_d[15:0] = cmp_a_buf_q;
      OFS_CMP_B:   rdata_d[15:0] = cmp_b_buf_q;
      OFS_CAPTURE: rdata_d[15:0] = capture_value_q;
      OFS_COUNT:   rdata_d[15:0] = count_value_q;
      OFS_STATUS:  rdata_d[7:0]  = status_q;
      OFS_PORT:    rdata_d[3:0]  = port_q;
      default:     rdata_d       = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      avs_readdata_o <= 32'h0000_0000;
    else if (avs_read_i && !ack_q)
      avs_readdata_o <= rdata_d;
  end

endmodule

`default_nettype wire

/* verif/tmc_pin_load.sv */
// Purpose: load on one compare pin
// Assumes: no pull resistor on the pin
// Notes:   an undriven pin shows a changing pattern
`timescale 1ns/1ps
`default_nettype none
module tmc_pin_load
(
  input  wire logic clk_i,
  input  wire logic pin_i,
  input  wire logic oe_i,
  output logic      level_o
);
  logic flip_q = 1'b0;
  always_ff @(posedge clk_i)
    flip_q <= !flip_q;
  assign level_o = oe_i ? pin_i : flip_q;
endmodule
`default_nettype wire

/* verif/tmc_timer16_bench.sv */
// Purpose: self-checking bench for tmc_timer16
// Assumes: model covers control A and control B registers
// Notes:   byte enables tied to lanes 0 and 1
`timescale 1ns/1ps
`default_nettype none
module tmc_timer16_bench
  import tmc_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic [4:0]  adr = 5'h00;
  logic        rdq = 1'b0;
  logic        wrq = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [1:0]  pins_q = 2'h0;
  logic [31:0] rdat;
  logic [31:0] got;
  logic [31:0] d;
  logic        wreq, pa, pa_oe, pb, pb_oe, lvl_a, lvl_b;
  logic [7:0]  mdl [2];
  logic [1:0]  oms [3] = '{OM_SET, OM_CLEAR, OM_TOGGLE};
  int          seed = 95118;
  int          fail_count = 0;
  int          checks_done = 0;
  tmc_timer16 uut (.clk_i(clk_i), .reset_i(reset_i), .avs_address_i(adr), .avs_read_i(rdq),
    .avs_write_i(wrq), .avs_writedata_i(wdat), .avs_byteenable_i(4'h3),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .external_count_pin_i(pins_q[0]),
    .capture_input_pin_i(pins_q[1]), .chan_a_wave_pin_o(pa), .chan_a_wave_pin_oe_o(pa_oe),
    .chan_b_wave_pin_o(pb), .chan_b_wave_pin_oe_o(pb_oe));
  tmc_pin_load pl_a (.clk_i(clk_i), .pin_i(pa), .oe_i(pa_oe), .level_o(lvl_a));
  tmc_pin_load pl_b (.clk_i(clk_i), .pin_i(pb), .oe_i(pb_oe), .level_o(lvl_b));
  initial
    forever #2 clk_i = ~clk_i;
  always @(posedge clk_i)
    pins_q <= 2'($random(seed));
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one idle edge first, so no request line is driven twice in a step
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] dv);
    int n;
    @(posedge clk_i);
    adr <= a;
    wdat <= dv;
    wrq <= w;
    rdq <= !w;
    @(posedge clk_i);
    for (n = 1; n < 16 && wreq !== 1'b0; n++)
      @(posedge clk_i);
    if (wreq !== 1'b0)
    begin
      fail_count++;
      stop_test();
    end
    got = rdat;
    wrq <= 1'b0;
    rdq <= 1'b0;
    if (w && a == OFS_CTRL_A)
      mdl[0] = dv[7:0] & CTRL_A_WMASK;
    if (w && a == OFS_CTRL_B)
      mdl[1] = dv[7:0] & CTRL_B_WMASK;
  endtask
  task automatic pinchk(input logic [3:0] e);
    repeat (2) @(negedge clk_i);
    check({lvl_b & pb_oe, lvl_a & pa_oe, pb_oe, pa_oe, pb, pa}, {e[3] & e[1], e[2] & e[0], e});
  endtask
  task automatic wait_a(input logic e);
    for (int n = 0; n < 600 && pa !== e; n++)
      @(negedge clk_i);
    if (pa !== e)
    begin
      fail_count++;
      stop_test();
    end
  endtask
  initial
  begin
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    bus(0, OFS_CTRL_A, 0);
    check(got, 0);
    bus(0, OFS_CTRL_B, 0);
    check(got, 0);
    repeat (12)
    begin
      d = $random(seed);
      bus(1, OFS_CTRL_A, d);
      bus(1, OFS_CTRL_B, d >> 8);
      bus(0, OFS_CTRL_A, 0);
      check(got, mdl[0]);
      bus(0, OFS_CTRL_B, 0);
      check(got, mdl[1]);
    end
    bus(1, OFS_CTRL_A, 0);
    bus(1, OFS_CTRL_B, 0);
    bus(1, OFS_PORT, 32'h0B);
    pinchk(4'hE);
    bus(1, OFS_PORT, 32'h04);
    pinchk(4'h1);
    bus(1, OFS_PORT, 32'h03);
    bus(1, OFS_CMP_A, 32'h5);
    bus(1, OFS_CMP_B, 32'h5);
    bus(1, OFS_CTRL_B, 32'(CS_DIV1));
    foreach (oms[i])
    begin
      bus(1, OFS_CTRL_A, {oms[i], oms[i], 4'h0});
      bus(1, OFS_COUNT, 0);
      wait_a(i != 1);
      pinchk({2'b11, {2{i != 1}}});
    end
    bus(1, OFS_PORT, 32'h07);
    bus(1, OFS_CTRL_A, 32'h51);
    pinchk(4'hD);
    bus(1, OFS_CTRL_B, 32'h09);
    pinchk(4'hD);
    bus(1, OFS_CTRL_B, 32'h11);
    wait_a(1);
    wait_a(0);
    pinchk(4'hC);
    bus(1, OFS_CMP_A, 32'h40);
    bus(1, OFS_CTRL_A, 32'h81);
    bus(1, OFS_CTRL_B, 32'h09);
    wait_a(1);
    wait_a(0);
    pinchk(4'hC);
    wait_a(1);
    pinchk(4'hD);
    @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    bus(0, OFS_CTRL_A, 0);
    check(got, 0);
    pinchk(4'h0);
    stop_test();
  end
endmodule
`default_nettype wire

/* verif/tmc_timer16_checker.sv */
// Purpose: port assertions for tmc_timer16
// Assumes: one wait state per bus access
// Notes:   shadows control A and port registers
`timescale 1ns/1ps
`default_nettype none
module tmc_timer16_checker
  import tmc_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic [4:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic        chan_a_wave_pin_o,
  input wire logic        chan_a_wave_pin_oe_o,
  input wire logic        chan_b_wave_pin_o,
  input wire logic        chan_b_wave_pin_oe_o
);
  logic       req;
  logic       wr_ok;
  logic [7:0] ca_q;
  logic [3:0] pt_q;
  assign req   = avs_read_i || avs_write_i;
  assign wr_ok = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  always_ff @(posedge clk_i)
    if (reset_i)
      ca_q <= 8'h00;
    else if (wr_ok && avs_address_i == OFS_CTRL_A)
      ca_q <= avs_writedata_i[7:0] & CTRL_A_WMASK;
  always_ff @(posedge clk_i)
    if (reset_i)
      pt_q <= 4'h0;
    else if (wr_ok && avs_address_i == OFS_PORT)
      pt_q <= avs_writedata_i[3:0];
  default clocking dclk @(posedge clk_i); endclocking
  default disable iff (reset_i);
  reset_clear_a:
    assert property ($past(reset_i) |-> !(chan_a_wave_pin_o || chan_a_wave_pin_oe_o
      || chan_b_wave_pin_o || chan_b_wave_pin_oe_o)) else $error("pins set after reset");
  wait_one_a:
    assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o) else $error("no answer");
  wait_new_a:
    assert property (req && !avs_waitrequest_o |=> !req || avs_waitrequest_o)
    else $error("no wait state");
  ctrl_read_a:
    assert property (avs_read_i && !avs_waitrequest_o && avs_address_i == OFS_CTRL_A
      |-> avs_readdata_o[7:0] == ca_q) else $error("control A readback wrong");
  dir_a_oe_a:
    assert property (wr_ok && avs_address_i == OFS_PORT
      |=> chan_a_wave_pin_oe_o == pt_q[PT_DIR_A]) else $error("pin A enable wrong");
  dir_b_oe_a:
    assert property (wr_ok && avs_address_i == OFS_PORT
      |=> chan_b_wave_pin_oe_o == pt_q[PT_DIR_B]) else $error("pin B enable wrong");
  port_a_pin_a:
    assert property (ca_q[7:6] == OM_OFF && $stable(ca_q) && $stable(pt_q)
      |-> chan_a_wave_pin_o == pt_q[PT_DATA_A]) else $error("pin A not port data");
  port_b_pin_a:
    assert property (ca_q[5:4] == OM_OFF && $stable(ca_q) && $stable(pt_q)
      |-> chan_b_wave_pin_o == pt_q[PT_DATA_B]) else $error("pin B not port data");
endmodule
bind tmc_timer16 tmc_timer16_checker chk (.clk_i(clk_i), .reset_i(reset_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .chan_a_wave_pin_o(chan_a_wave_pin_o), .chan_a_wave_pin_oe_o(chan_a_wave_pin_oe_o),
  .chan_b_wave_pin_o(chan_b_wave_pin_o), .chan_b_wave_pin_oe_o(chan_b_wave_pin_oe_o));
`default_nettype wire
